// *** sacp_port.sv ***
/*
  Digital side of a 12-bit serial-output converter: frame handling,
  track/hold control, output shift and normal/shutdown mode.
  Assumes shift clock and frame select are pins far slower than mclk,
  and the conversion core supplies a settled result on convResult.
*/
`timescale 1ns/10ps
module sacp_port
  import sacp_pkg::*;
#(
  parameter int RES_W = RESULT_W
)
(
  input  wire logic                       mclk,
  input  wire logic                       rst_b,
  input  wire logic                       frameSel_b,
  input  wire logic                       shiftClk,
  input  wire logic [sacp_pkg::RESULT_W-1:0] convResult,
  output logic                            result_serial_out,
  output logic                            resultOutEn,
  output logic                            holdMode,
  output logic                            sampleStrobe,
  output logic                            shutdownMode,
  output logic                            resultInvalid
);
  import sacp_pkg::*;

  // Elaboration guard: the shifter is sized from the packaged width
  if (RES_W != RESULT_W)
  begin : g_bad_width
    $error("RES_W must equal the packaged result width");
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and edge detection

  logic selSync;
  logic clkSync;
  logic selDly_reg;
  logic clkDly_reg;
  logic selFall;
  logic selRise;
  logic clkFall;
  logic clkRise;

  sacp_sync #(.RESET_VAL(1'b1)) uSyncSel
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pinIn   (frameSel_b),
    .pinSync (selSync)
  );

  sacp_sync #(.RESET_VAL(1'b0)) uSyncClk
  (
    .mclk    (mclk),
    .rst_b   (rst_b),
    .pinIn   (shiftClk),
    .pinSync (clkSync)
  );

  // Delayed copies for edges
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      selDly_reg <= 1'b1;
      clkDly_reg <= 1'b0;
    end
    else
    begin
      selDly_reg <= selSync;
      clkDly_reg <= clkSync;
    end
  end

  assign selFall = selDly_reg & ~selSync;
  assign selRise = ~selDly_reg & selSync;
  // Clock edges only count inside a frame
  assign clkFall = ~selSync & clkDly_reg & ~clkSync;
  assign clkRise = ~selSync & ~clkDly_reg & clkSync;

  ////////////////////////////////////////////////////////////////////////
  // Frame edge counters

  logic [CNT_W-1:0] fallCnt_reg;
  logic [CNT_W-1:0] riseCnt_reg;

  // Counts restart on every frame so positions are per frame
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      fallCnt_reg <= '0;
      riseCnt_reg <= '0;
    end
    else if (selSync)
    begin
      fallCnt_reg <= '0;
      riseCnt_reg <= '0;
    end
    else
    begin
      // Saturate so an idled-low select cannot wrap the count
      if (clkFall && fallCnt_reg != 5'h1f)
        fallCnt_reg <= fallCnt_reg + 5'h01;
      if (clkRise && riseCnt_reg != 5'h1f)
        riseCnt_reg <= riseCnt_reg + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frame state and track/hold

  sacp_state_t state_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      state_reg <= SACP_IDLE;
    else
    begin
      case (state_reg)
        SACP_IDLE:
          if (selFall)
            state_reg <= SACP_SHIFT;
        SACP_SHIFT:
          if (selRise)
            state_reg <= SACP_IDLE;
          else if (clkFall && fallCnt_reg == LAST_FALL - 5'h01)
            state_reg <= SACP_DONE;
        SACP_DONE:
          // Select idled low waits here for the rise
          if (selRise)
            state_reg <= SACP_IDLE;
        default:
          state_reg <= SACP_IDLE;
      endcase
    end
  end

  // Hold from select fall until the 13th rising edge
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      holdMode <= 1'b0;
    else if (selFall)
      holdMode <= 1'b1;
    else if (clkRise && riseCnt_reg == TRACK_RISE - 5'h01)
      holdMode <= 1'b0;
    else if (selRise)
      holdMode <= 1'b0;
  end

  // Sample instant pulse for the core
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sampleStrobe <= 1'b0;
    else
      sampleStrobe <= selFall;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output shifter: bit changes only on shift-clock falling edges and on select fall

  logic [LEAD_ZEROS+RESULT_W-1:0] shift_reg;

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      shift_reg         <= '0;
      result_serial_out <= 1'b0;
    end
    else if (selFall)
    begin
      shift_reg         <= {{LEAD_ZEROS{1'b0}}, convResult};
      result_serial_out <= 1'b0; // Leading zero shown before first fall
    end
    else if (clkFall && state_reg == SACP_SHIFT)
    begin
      result_serial_out <= shift_reg[LEAD_ZEROS+RESULT_W-1];
      shift_reg         <= {shift_reg[LEAD_ZEROS+RESULT_W-2:0], 1'b0};
    end
  end

  // Enable follows the frame; ends at 16th fall or select rise
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      resultOutEn <= 1'b0;
    else if (selFall)
      resultOutEn <= 1'b1;
    else if (selRise)
      resultOutEn <= 1'b0;
    else if (clkFall && fallCnt_reg == LAST_FALL - 5'h01)
      resultOutEn <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////
  // Operating mode

  // Mode at frame start, restored by the early-rise noise guard
  logic startShut_reg;

  // Power-up mode is unknown in silicon; reset chooses shutdown
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      shutdownMode <= 1'b1;
    else if (selFall)
      shutdownMode <= 1'b0;
    else if (selRise && fallCnt_reg < NOISE_FALL)
      shutdownMode <= startShut_reg;
    else if (selRise && fallCnt_reg < MODE_FALL)
      shutdownMode <= 1'b1;
  end

  // Noise on the select must not flip the mode, so the mode the frame
  // started in is kept for a rise before the second fall
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      startShut_reg <= 1'b1;
    else if (selFall)
      startShut_reg <= shutdownMode;
  end

  // First word after leaving shutdown is flagged unusable
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      resultInvalid <= 1'b1;
    else if (selFall)
      resultInvalid <= shutdownMode;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_hold_on_fall;
    @(posedge mclk) disable iff (!rst_b)
    selFall |=> holdMode && resultOutEn;
  endproperty
  a_hold_on_fall: assert property (p_hold_on_fall)
    else $error("Hold or output enable missing after select fall");

  property p_track_13;
    @(posedge mclk) disable iff (!rst_b)
    (clkRise && riseCnt_reg == 5'h0c && !selRise) |=> !holdMode;
  endproperty
  a_track_13: assert property (p_track_13)
    else $error("Track not resumed on 13th rising edge");

  property p_float_16;
    @(posedge mclk) disable iff (!rst_b)
    (clkFall && fallCnt_reg == 5'h0f) |=> !resultOutEn;
  endproperty
  a_float_16: assert property (p_float_16)
    else $error("Output still driven after 16th fall");

  property p_float_rise;
    @(posedge mclk) disable iff (!rst_b)
    selRise |=> !resultOutEn ##1 !resultOutEn;
  endproperty
  a_float_rise: assert property (p_float_rise)
    else $error("Output driven after select rise");

  property p_zero_lead;
    @(posedge mclk) disable iff (!rst_b)
    (clkFall && state_reg == SACP_SHIFT && fallCnt_reg < 5'h03)
      |=> !result_serial_out;
  endproperty
  a_zero_lead: assert property (p_zero_lead)
    else $error("Leading bit not zero");

  property p_stable_bit;
    @(posedge mclk) disable iff (!rst_b)
    (!clkFall && !selFall) |=> $stable(result_serial_out);
  endproperty
  a_stable_bit: assert property (p_stable_bit)
    else $error("Output bit changed away from a falling edge");

  property p_shutdown;
    @(posedge mclk) disable iff (!rst_b)
    (selRise && fallCnt_reg >= 5'h02 && fallCnt_reg < 5'h0a)
      |=> shutdownMode;
  endproperty
  a_shutdown: assert property (p_shutdown)
    else $error("Shutdown not entered");

  property p_no_mode_change;
    @(posedge mclk) disable iff (!rst_b)
    (selRise && fallCnt_reg < 5'h02) |=> shutdownMode == startShut_reg;
  endproperty
  a_no_mode_change: assert property (p_no_mode_change)
    else $error("Mode changed on early select rise");

  property p_stay_shut;
    @(posedge mclk) disable iff (!rst_b)
    (shutdownMode && !selFall) |=> shutdownMode;
  endproperty
  a_stay_shut: assert property (p_stay_shut)
    else $error("Shutdown left without select fall");

  property p_normal_entry;
    @(posedge mclk) disable iff (!rst_b)
    selFall |=> !shutdownMode && resultInvalid == $past(shutdownMode);
  endproperty
  a_normal_entry: assert property (p_normal_entry)
    else $error("Normal entry or invalid flag wrong");

  property p_count_clear;
    @(posedge mclk) disable iff (!rst_b)
    selSync |=> fallCnt_reg == 5'h00 && riseCnt_reg == 5'h00;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("Edge count not cleared");

  c_full_word: cover property (@(posedge mclk) disable iff (!rst_b)
    state_reg == SACP_SHIFT ##1 state_reg == SACP_DONE);
  c_shutdown: cover property (@(posedge mclk) disable iff (!rst_b)
    !shutdownMode ##1 shutdownMode);
  c_abort: cover property (@(posedge mclk) disable iff (!rst_b)
    selRise && fallCnt_reg > 5'h0a && fallCnt_reg < 5'h10);

endmodule : sacp_port

// *** sacp_pkg.sv ***
/*
  Constants shared by the serial converter port: frame edge positions,
  word layout and mode encoding.
  Assumes one system clock; pins are sampled by the main module.
*/
package sacp_pkg;

  localparam int RESULT_W      = 12;     // Result width
  localparam int LEAD_ZEROS    = 3;      // Zero bits before the result
  localparam int CNT_W         = 5;      // Edge counter width
  localparam logic [4:0] TRACK_RISE  = 5'h0d; // Rising edge back to track
  localparam logic [4:0] LAST_FALL   = 5'h10; // Falling edge ending word
  localparam logic [4:0] MODE_FALL   = 5'h0a; // Falling edge keeping normal
  localparam logic [4:0] NOISE_FALL  = 5'h02; // Below this no mode change

  typedef enum logic {SACP_NORMAL, SACP_SHUTDOWN} sacp_mode_t;
  typedef enum logic [1:0] {SACP_IDLE, SACP_SHIFT, SACP_DONE} sacp_state_t;

endpackage : sacp_pkg

// *** sacp_sync.sv ***
/*
  Two-stage synchroniser for one pin level.
  Assumes the pin is asynchronous to mclk.
*/
`timescale 1ns/10ps
module sacp_sync
#(
  parameter logic RESET_VAL = 1'b0
)
(
  input  wire logic mclk,
  input  wire logic rst_b,
  input  wire logic pinIn,
  output logic      pinSync
);

  logic stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      stage1_reg <= RESET_VAL;
      pinSync    <= RESET_VAL;
    end
    else
    begin
      stage1_reg <= pinIn;
      pinSync    <= stage1_reg;
    end
  end

endmodule : sacp_sync

// *** sacp_host.sv ***
/*
  Serial host model: frames conversions on the select pin, makes the
  shift clock and reads the result word bit by bit.
  Assumes mclk runs far faster than the shift clock made here.
*/
`timescale 1ns/10ps
module sacp_host
#(
  parameter int HALF = 8
)
(
  input  wire logic mclk,
  input  wire logic serialIn,
  input  wire logic outEn,
  input  wire logic holdIn,
  input  wire logic invIn,
  output logic      frameSel_b,
  output logic      shiftClk
);
  logic [15:0] capWord;
  logic        holdSeen;
  logic        enSeen;
  logic        invSeen;
  logic        lineLvl;

  ////////////////////////////////////////////////////////////////////////
  // Released line has no pull; it shows the inverse of the last bit
  // so a stale value can never pass as data
  assign lineLvl = outEn ? serialIn : ~serialIn;

  // Select idles high, clock idles high and stands still
  initial
  begin
    frameSel_b = 1'b1;
    shiftClk   = 1'b1;
    capWord    = 16'h0000;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : wait_cyc

  // Clock pulses with select high, which the port must ignore
  task automatic idle_clocks(input int n);
    wait_cyc(1);
    repeat (n)
    begin
      shiftClk = 1'b0;
      wait_cyc(HALF);
      shiftClk = 1'b1;
      wait_cyc(HALF);
    end
  endtask : idle_clocks

  // One frame; fewer than sixteen falls cuts the word short
  task automatic run_frame(input int falls);
    wait_cyc(1);
    capWord    = 16'h0000;
    frameSel_b = 1'b0;
    wait_cyc(HALF);
    // Sixteen falls read the whole word and keep normal mode
    repeat (falls)
    begin
      capWord  = {capWord[14:0], lineLvl};
      shiftClk = 1'b0;
      wait_cyc(HALF);
      shiftClk = 1'b1;
      wait_cyc(HALF);
    end
    holdSeen   = holdIn;
    enSeen     = outEn;
    invSeen    = invIn;
    frameSel_b = 1'b1;
    wait_cyc(4 * HALF);
  endtask : run_frame
endmodule : sacp_host

// *** test_serial_adc_conversion_port.sv ***
/*
  Self-checking bench for the serial converter port with a host model.
  Assumes the port's own assertions sit in its design files.
*/
`timescale 1ns/10ps
module test_serial_adc_conversion_port;
  import sacp_pkg::*;

  typedef struct packed {
    logic [11:0] res;
    logic [4:0]  falls;
    logic        shut;
    logic        inv;
    logic        hold;
    logic        en;
  } sacp_row_t;

  logic                mclk;
  logic                rst_b;
  wire logic           frameSel_b;
  wire logic           shiftClk;
  logic [RESULT_W-1:0] convResult;
  logic                serOut;
  logic                outEn;
  logic                holdMode;
  logic                strobe;
  logic                shutdownMode;
  logic                resultInvalid;
  int                  n_errors;
  int                  num_checks;
  int                  strobes;
  sacp_row_t           r;
  // Result, falls, then shutdown, invalid, hold and enable expected
  sacp_row_t           rows [0:11] = '{
    {12'ha5c, 5'd16, 4'b0100}, {12'h5a3, 5'd16, 4'b0000},
    {12'hfff, 5'd12, 4'b0011}, {12'h123, 5'd13, 4'b0001},
    {12'h800, 5'd5,  4'b1011}, {12'h001, 5'd16, 4'b0100},
    {12'h7ff, 5'd10, 4'b0011}, {12'h3c3, 5'd2,  4'b1011},
    {12'h0f0, 5'd1,  4'b1111}, {12'h555, 5'd16, 4'b0100},
    {12'h555, 5'd1,  4'b0011}, {12'habc, 5'd9,  4'b1011}};

  ////////////////////////////////////////////////////////////////////////
  sacp_port u_sacp_port (
    .mclk              (mclk),
    .rst_b             (rst_b),
    .frameSel_b        (frameSel_b),
    .shiftClk          (shiftClk),
    .convResult        (convResult),
    .result_serial_out (serOut),
    .resultOutEn       (outEn),
    .holdMode          (holdMode),
    .sampleStrobe      (strobe),
    .shutdownMode      (shutdownMode),
    .resultInvalid     (resultInvalid)
  );

  sacp_host #(.HALF(8)) u_sacp_host (
    .mclk       (mclk),
    .serialIn   (serOut),
    .outEn      (outEn),
    .holdIn     (holdMode),
    .invIn      (resultInvalid),
    .frameSel_b (frameSel_b),
    .shiftClk   (shiftClk)
  );

  ////////////////////////////////////////////////////////////////////////
  // 100 MHz clock
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  // Sample pulses over the run, one per frame
  always @(posedge mclk) if (strobe === 1'b1) strobes++;

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  // Watchdog sized well past the frames below
  initial
  begin
    #400000;
    n_errors++;
    $display("[ERR] %0t run did not finish", $time);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////
  // Reset, table of frames, then strobe count and a mid-run reset
  initial
  begin
    n_errors   = 0;
    num_checks = 0;
    strobes    = 0;
    rst_b      = 1'b0;
    convResult = 12'h000;
    repeat (12) @(posedge mclk);
    #1 rst_b = 1'b1;
    check({outEn, holdMode, shutdownMode, resultInvalid}, 4'h3, "rst");
    // Select high: these edges must not count toward the next frame
    u_sacp_host.idle_clocks(5);
    for (int i = 0; i < 12; i++)
    begin
      r          = rows[i];
      convResult = r.res;
      u_sacp_host.run_frame(int'(r.falls));
      check(u_sacp_host.capWord,
            16'({4'h0, r.res} >> (16 - r.falls)), "word");
      check({u_sacp_host.holdSeen, u_sacp_host.enSeen}, {r.hold, r.en},
            "hold en");
      check({u_sacp_host.invSeen, shutdownMode, outEn},
            {r.inv, r.shut, 1'b0}, "mode");
    end
    check(16'(strobes), 16'd12, "strobes");
    // Asynchronous reset in mid-run returns to the reset state
    u_sacp_host.run_frame(16);
    rst_b = 1'b0;
    @(posedge mclk);
    #1;
    check({outEn, holdMode, shutdownMode, resultInvalid}, 4'h3, "rst2");
    rst_b = 1'b1;
    // First frame after the reset starts from shutdown and is flagged
    convResult = 12'h6b1;
    u_sacp_host.run_frame(16);
    check(u_sacp_host.capWord, 16'h06b1, "word2");
    check({u_sacp_host.invSeen, shutdownMode, outEn}, 3'b100,
          "mode2");
    end_of_test();
  end
endmodule : test_serial_adc_conversion_port
